/* File: rtl/zero_compare_branch_defines.vh */
// Constants for the compare-with-zero branch unit.
// Included by the unit's design file; definitions only.
`ifndef ZERO_COMPARE_BRANCH_DEFINES_VH
`define ZERO_COMPARE_BRANCH_DEFINES_VH

`define OPC_MSB 31
`define OPC_LSB 26
`define SRC_MSB 25
`define SRC_LSB 21
`define ZFLD_MSB 20
`define ZFLD_LSB 16
`define OFS_MSB 15
`define OFS_LSB 0

`define OPC_GT_ZERO 6'h07
`define OPC_GT_ZERO_LIKELY 6'h17
`define OPC_LE_ZERO 6'h06
`define OPC_LE_ZERO_LIKELY 6'h16

`define SIGN_BIT_64 63
`define SIGN_BIT_32 31
`define SLOT_PC_STEP 3'h4

`endif

/* File: rtl/zero_compare_branch_unit.v */
// Decode and resolve four compare-with-zero branches.
// Assumes the pipeline presents one issued instruction per valid cycle,
// with its PC and the source register value read in that same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "zero_compare_branch_defines.vh"

module zero_compare_branch_unit #(
	parameter XLEN = 64
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire issue_valid_i,
	input wire [31:0] instr_i,
	input wire [XLEN-1:0] instr_pc_i,
	input wire [XLEN-1:0] source_register_field_value_i,
	input wire mode64_i,
	output reg branch_seen_o,
	output reg [4:0] source_register_field_o,
	output reg redirect_o,
	output reg [XLEN-1:0] redirect_pc_o,
	output reg nullify_o
);

	// Only one thing is ever waited for: the delay slot of a decoded branch
	localparam ST_IDLE = 1'b0;
	localparam ST_SLOT = 1'b1;

	wire [5:0] opcode;
	wire [4:0] zero_field;
	wire [15:0] offset;
	wire is_gt;
	wire is_gt_likely;
	wire is_le;
	wire is_le_likely;
	wire is_branch;
	reg sign_bit;
	reg value_zero;
	wire cond_gt;
	wire cond_le;
	wire taken;
	wire likely;
	wire [XLEN-1:0] offset_ext;
	wire [XLEN-1:0] slot_pc;
	wire [XLEN-1:0] target;

	reg state_reg;
	reg state_next;
	reg taken_reg;
	reg taken_next;
	reg kill_reg;
	reg kill_next;
	reg [XLEN-1:0] target_reg;
	reg [XLEN-1:0] target_next;
	reg branch_seen_next;
	reg redirect_next;
	reg [XLEN-1:0] redirect_pc_next;
	reg nullify_next;

	assign opcode = instr_i[`OPC_MSB:`OPC_LSB];
	assign zero_field = instr_i[`ZFLD_MSB:`ZFLD_LSB];
	assign offset = instr_i[`OFS_MSB:`OFS_LSB];
	// One matcher per branch kind; a word with a nonzero middle field belongs to
	// another instruction and is left alone
	branch_opcode_match #(
		.OPCODE(`OPC_GT_ZERO)
	) u_match_gt (
		.opcode_i(opcode),
		.zero_field_i(zero_field),
		.match_o(is_gt)
	);

	branch_opcode_match #(
		.OPCODE(`OPC_GT_ZERO_LIKELY)
	) u_match_gt_likely (
		.opcode_i(opcode),
		.zero_field_i(zero_field),
		.match_o(is_gt_likely)
	);

	branch_opcode_match #(
		.OPCODE(`OPC_LE_ZERO)
	) u_match_le (
		.opcode_i(opcode),
		.zero_field_i(zero_field),
		.match_o(is_le)
	);

	branch_opcode_match #(
		.OPCODE(`OPC_LE_ZERO_LIKELY)
	) u_match_le_likely (
		.opcode_i(opcode),
		.zero_field_i(zero_field),
		.match_o(is_le_likely)
	);

	assign is_branch = is_gt | is_gt_likely | is_le | is_le_likely;
	assign likely = is_gt_likely | is_le_likely;

	// Sign and zero follow the operand width chosen for this issue
	always @* begin
		if (mode64_i) begin
			sign_bit = source_register_field_value_i[`SIGN_BIT_64];
			value_zero = (source_register_field_value_i == {XLEN{1'b0}});
		end else begin
			sign_bit = source_register_field_value_i[`SIGN_BIT_32];
			value_zero = (source_register_field_value_i[`SIGN_BIT_32:0] == 32'h00000000);
		end
	end

	// Both tests must hold; an OR here would take the branch for negative values too
	assign cond_gt = ~sign_bit & ~value_zero;
	assign cond_le = sign_bit | value_zero;
	// Likely forms share the condition; they differ only in what happens to the slot
	assign taken = ((is_gt | is_gt_likely) & cond_gt)
		| ((is_le | is_le_likely) & cond_le);

	// The offset counts words, so the two low bits of the extended offset are always zero
	assign offset_ext = {{(XLEN-18){offset[15]}}, offset, 2'b00};
	assign slot_pc = instr_pc_i + {{(XLEN-3){1'b0}}, `SLOT_PC_STEP};
	assign target = slot_pc + offset_ext;

	// A pending branch keeps its decision and target until its slot issues, however late
	always @* begin
		state_next = state_reg;
		taken_next = taken_reg;
		kill_next = kill_reg;
		target_next = target_reg;
		branch_seen_next = 1'b0;
		redirect_next = 1'b0;
		redirect_pc_next = redirect_pc_o;
		nullify_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				// Decoding only while idle keeps a branch in the slot from opening a new pair
				if (issue_valid_i && is_branch) begin
					state_next = ST_SLOT;
					branch_seen_next = 1'b1;
					taken_next = taken;
					kill_next = likely & ~taken;
					target_next = target;
				end
			end
			ST_SLOT: begin
				// Wait for the delay slot to issue before acting
				if (issue_valid_i) begin
					state_next = ST_IDLE;
					redirect_next = taken_reg;
					redirect_pc_next = target_reg;
					nullify_next = kill_reg;
					taken_next = 1'b0;
					kill_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk_i) begin
		// Clearing the state drops a branch whose slot never came
		if (rst_i) begin
			state_reg <= ST_IDLE;
			taken_reg <= 1'b0;
			kill_reg <= 1'b0;
			target_reg <= {XLEN{1'b0}};
			branch_seen_o <= 1'b0;
			source_register_field_o <= 5'h00;
			redirect_o <= 1'b0;
			redirect_pc_o <= {XLEN{1'b0}};
			nullify_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			taken_reg <= taken_next;
			kill_reg <= kill_next;
			target_reg <= target_next;
			branch_seen_o <= branch_seen_next;
			source_register_field_o <= instr_i[`SRC_MSB:`SRC_LSB];
			// Redirect after the slot issues; a not-taken plain form just falls through
			redirect_o <= redirect_next;
			// The target stays on its port until the next slot so a late reader still sees it
			redirect_pc_o <= redirect_pc_next;
			// Only likely forms kill the slot; plain forms let it run
			nullify_o <= nullify_next;
		end
	end

endmodule

// One decoder per branch kind. A word whose middle field is not zero
// belongs to another instruction and must not be taken as a branch here.
module branch_opcode_match #(
	parameter [5:0] OPCODE = 6'h00
) (
	input wire [5:0] opcode_i,
	input wire [4:0] zero_field_i,
	output wire match_o
);

	assign match_o = (opcode_i == OPCODE) && (zero_field_i == 5'h00);

endmodule

`default_nettype wire

/* File: tb/zcb_chk.sv */
// Port checker for the zero-compare branch unit.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module zcb_chk (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic issue_valid_i,
	input wire logic branch_seen_o,
	input wire logic redirect_o,
	input wire logic nullify_o,
	input wire logic [31:0] instr_i,
	input wire logic [63:0] redirect_pc_o,
	input wire logic [4:0] source_register_field_o
);
	wire br = issue_valid_i && {instr_i[31], instr_i[29:27], instr_i[20:16]} == 9'h060;
	reg p = 1'b0;
	reg lk = 1'b0;
	wire sl = p && issue_valid_i;
	// A branch sitting in a delay slot must not open a new pairing
	always @(posedge core_clk_i) begin
		p <= rst_i ? 1'b0 : issue_valid_i ? !p && br : p;
		if (issue_valid_i && !p) lk <= instr_i[30];
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_seen_follows: assert property (br && !p |=> branch_seen_o) else $error("seen");
	a_seen_cause: assert property (branch_seen_o |-> $past(br && !p)) else $error("seen");
	a_src_copy: assert property (!$past(rst_i) |->
		source_register_field_o == $past(instr_i[25:21])) else $error("src");
	a_target_holds: assert property (!$past(sl) && !$past(rst_i) |->
		$stable(redirect_pc_o)) else $error("hold");
	a_redirect_slot: assert property (redirect_o |-> $past(sl)) else $error("redir");
	a_likely_resolves: assert property (sl && lk |=> redirect_o ^ nullify_o) else $error("lk");
	a_nullify_cause: assert property (nullify_o |-> $past(sl && lk)) else $error("null");
	c_redirect: cover property (redirect_o);
	c_nullify: cover property (nullify_o);
	c_seen: cover property (branch_seen_o);
endmodule
bind zero_compare_branch_unit zcb_chk u_chk(.*);
`default_nettype wire

/* File: tb/zero_compare_branch_unit_test.sv */
// Bench for the zero-compare branch unit.
// Drives issue slots on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module zero_compare_branch_unit_test;
	logic clk = 0, rst = 1, vld = 0, md = 1;
	logic [31:0] ins = 0;
	logic [63:0] val = 0, pc = 64'h1000;
	wire seen, redir, nul;
	wire [4:0] src;
	wire [63:0] rpc;
	int error_cnt = 0, checks = 0;
	always #2 clk = ~clk;
	zero_compare_branch_unit u_dut(.core_clk_i(clk), .rst_i(rst), .issue_valid_i(vld),
		.instr_i(ins), .instr_pc_i(pc), .source_register_field_value_i(val),
		.mode64_i(md), .branch_seen_o(seen), .source_register_field_o(src),
		.redirect_o(redir), .redirect_pc_o(rpc), .nullify_o(nul));
	task chk(input [63:0] g, e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task run(input [5:0] op, input [63:0] v, input [15:0] o, input [1:0] e, input [31:0] s);
		@(negedge clk) {vld, ins, val} = {1'b1, op, 10'h060, o, v};
		@(negedge clk) ins = s;
		chk({seen, src}, 6'h23);
		@(negedge clk) vld = 0;
		chk({seen, redir, nul}, e);
		if (e[1]) chk(rpc, pc + 64'h4 + {{46{o[15]}}, o, 2'b00});
	endtask
	task t_sign;
		run(6'h07, 64'h5, 16'hfffc, 2'h2, 0);
		run(6'h17, 64'h0, 16'h0010, 2'h1, 0);
		run(6'h16, '1, 16'h7fff, 2'h2, 0);
		run(6'h06, 64'h5, 16'h8000, 2'h0, 0);
		$display("sign test done");
	endtask
	task t_modes;
		md = 0;
		pc = 64'hfffffff8;
		run(6'h06, 64'h80000000, 16'h1, 2'h2, 0);
		run(6'h17, 64'h100000000, 16'h1, 2'h1, 0);
		md = 1;
		run(6'h07, 64'h80000000, 16'h1, 2'h2, 0);
		run(6'h16, 64'h100000000, 16'h1, 2'h1, 0);
		$display("mode test done");
	endtask
	task t_refuse;
		run(6'h07, 64'h5, 16'h4, 2'h2, 32'h1c600004);
		@(negedge clk) {vld, ins, val} = {1'b1, 6'h07, 10'h060, 16'h0002, 64'h1};
		@(negedge clk) vld = 0;
		@(negedge clk) {vld, ins} = {1'b1, 32'h0};
		chk({seen, redir, nul}, 0);
		@(negedge clk) vld = 0;
		chk(redir, 1);
		chk(rpc, pc + 64'hc);
		@(negedge clk) {vld, ins} = {1'b1, 32'h1c610004};
		@(negedge clk) vld = 0;
		chk(seen, 0);
		$display("refuse test done");
	endtask
	task t_reset;
		@(negedge clk) {vld, ins, val} = {1'b1, 6'h17, 10'h060, 16'h0010, 64'h0};
		@(negedge clk) {vld, rst} = 2'b01;
		@(negedge clk) {vld, rst, ins} = {2'b10, 32'h0};
		chk({seen, redir, nul}, 0);
		@(negedge clk) vld = 0;
		chk({seen, redir, nul}, 0);
		$display("reset test done");
	endtask
	task report_and_stop;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 0;
		t_sign;
		t_modes;
		t_refuse;
		t_reset;
		report_and_stop;
	end
endmodule
`default_nettype wire
